/* File: include/mioac_pkg.sv */
// Constants, register map and carrier types of the motor I/O and alarm block
package mioac_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned DEB_TIME_MS = 1;
    localparam int unsigned RAMP_TICK_MS = 1;
    localparam int unsigned HOLD_TIME_S = 5;
    localparam int unsigned IND_TIME_S = 1;
    localparam int unsigned DEB_CYC = CLK_HZ / MS_PER_S * DEB_TIME_MS;
    localparam int unsigned RAMP_CYC = CLK_HZ / MS_PER_S * RAMP_TICK_MS;
    localparam int unsigned HOLD_CYC = CLK_HZ * HOLD_TIME_S;
    localparam int unsigned IND_CYC = CLK_HZ * IND_TIME_S;
    localparam int unsigned CNT_W = 28;
    localparam int unsigned TACH_PULSES_REV = 12;
    localparam int unsigned SEC_PER_MIN = 60;
    localparam int unsigned TACH_STEP = 2 * TACH_PULSES_REV;
    localparam logic [31:0] TACH_WRAP = SEC_PER_MIN * CLK_HZ;
    localparam int unsigned NUM_IN = 6;
    localparam int unsigned NUM_OUT = 2;
    localparam int unsigned NUM_SETS = 4;
    localparam int unsigned ADDR_W = 8;
    // Input function codes
    localparam logic [2:0] FN_NONE = 3'h0;
    localparam logic [2:0] FN_FWD = 3'h1;
    localparam logic [2:0] FN_REV = 3'h2;
    localparam logic [2:0] FN_DS0 = 3'h3;
    localparam logic [2:0] FN_DS1 = 3'h4;
    localparam logic [2:0] FN_RST = 3'h5;
    localparam logic [2:0] FN_COAST = 3'h6;
    localparam logic [2:0] FN_EXT = 3'h7;
    // Output function codes
    localparam logic [1:0] OS_TACH = 2'h0;
    localparam logic [1:0] OS_ALMOK = 2'h1;
    localparam logic [1:0] OS_THERM = 2'h2;
    localparam logic [1:0] OS_WARN = 2'h3;
    localparam logic [3:0] ALM_NONE = 4'h0;
    localparam logic [3:0] ALM_EXT = 4'h1;
    localparam logic [3:0] ALM_PROT = 4'h2;
    localparam logic [1:0] IND_NONE = 2'h0;
    localparam logic [1:0] IND_LOCK = 2'h1;
    localparam logic [1:0] IND_UNLOCK = 2'h2;
    localparam logic [1:0] IND_LOCKED_EDIT = 2'h3;
    // Register byte addresses
    localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] A_IN_MAP = 8'h04;
    localparam logic [ADDR_W-1:0] A_OUT_MAP = 8'h08;
    localparam logic [ADDR_W-1:0] A_ACCEL = 8'h0c;
    localparam logic [ADDR_W-1:0] A_DECEL = 8'h10;
    localparam logic [ADDR_W-1:0] A_SPEED0 = 8'h14;
    localparam logic [ADDR_W-1:0] A_SPEED3 = 8'h20;
    localparam logic [ADDR_W-1:0] A_STATUS = 8'h24;
    localparam logic [ADDR_W-1:0] A_SPEED_NOW = 8'h28;
    localparam logic [17:0] RST_IN_MAP = 18'h2_e8d1;
    localparam logic [3:0] RST_OUT_MAP = 4'h4;
    localparam logic [15:0] RST_STEP = 16'h0002;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } mioac_axi_req_t;
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } mioac_axi_rsp_t;
endpackage

/* File: rtl/mioac_top.sv */
// Motor terminal I/O, run control, alarm reaction and edit lock
`timescale 1ns/10ps
module mioac_top #(
    parameter int unsigned DEB_CYCLES = mioac_pkg::DEB_CYC,
    parameter int unsigned RAMP_CYCLES = mioac_pkg::RAMP_CYC,
    parameter int unsigned HOLD_CYCLES = mioac_pkg::HOLD_CYC,
    parameter int unsigned IND_CYCLES = mioac_pkg::IND_CYC
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // Register bus
    input wire mioac_pkg::mioac_axi_req_t AXI_REQ,
    output mioac_pkg::mioac_axi_rsp_t AXI_RSP,
    // Terminal and sensor pins
    input wire logic [5:0] IN_TERM,
    input wire logic THERMAL_PIN,
    input wire logic AC_POWER,
    input wire logic WARN_COND,
    input wire logic PROT_FAULT,
    // Panel
    input wire logic KEY_SET,
    input wire logic KEY_MODE,
    input wire logic TOP_SCREEN,
    // Motor drive and indications
    output logic [1:0] OUT_TERM,
    output logic MOTOR_DRIVE,
    output logic MOTOR_CW,
    output logic MOTOR_BRAKE,
    output logic [15:0] SPEED_REF,
    output logic ALARM_LED,
    output logic [3:0] ALARM_CODE,
    output logic [1:0] PANEL_IND,
    output logic EDIT_LOCKED
);
    import mioac_pkg::*;

    localparam int unsigned NUM_DEB = 9;
    localparam logic [CNT_W-1:0] DEB_LIM = CNT_W'(DEB_CYCLES - 1);
    localparam logic [CNT_W-1:0] RAMP_LIM = CNT_W'(RAMP_CYCLES - 1);
    localparam logic [CNT_W-1:0] HOLD_LIM = CNT_W'(HOLD_CYCLES);
    localparam logic [CNT_W-1:0] IND_LIM = CNT_W'(IND_CYCLES);

    typedef struct packed {
        logic [NUM_DEB-1:0] s1;
        logic [NUM_DEB-1:0] s2;
        logic [NUM_DEB-1:0] samp;
        logic [NUM_DEB-1:0] deb;
        logic [2:0] l1;
        logic [2:0] l2;
        logic [CNT_W-1:0] deb_cnt;
        logic [CNT_W-1:0] ramp_cnt;
        logic [CNT_W-1:0] hold_cnt;
        logic [CNT_W-1:0] ind_cnt;
        logic rst_prev;
        logic alarm;
        logic [3:0] alarm_code;
        logic lock;
        logic [1:0] ind;
        logic running;
        logic dir_rev;
        logic brake;
        logic [15:0] speed;
        logic [31:0] tach_acc;
        logic tach;
        logic [1:0] out_term;
        logic dir_swap;
        logic [NUM_IN-1:0][2:0] in_map;
        logic [NUM_OUT-1:0][1:0] out_map;
        logic [15:0] accel;
        logic [15:0] decel;
        logic [NUM_SETS-1:0][15:0] op_speed;
        logic aw_got;
        logic w_got;
        logic [ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } mioac_state_t;

    mioac_state_t r_ff;
    mioac_state_t nxt_r;

    // True when any terminal carrying the function is on
    function automatic logic fn_active(input logic [NUM_IN-1:0][2:0] map,
                                       input logic [NUM_IN-1:0] lvl,
                                       input logic [2:0] code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < NUM_IN; i++) begin
            if (map[i] == code && lvl[i]) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    function automatic logic [31:0] wr_merge(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = data[b*8 +: 8];
            end
        end
        return res;
    endfunction

    logic forward_run, reverse_run, coast, ext_trip, fault_rst, alarm_set, thermal_open;
    logic warn, key_one, ramp_tick, want, fire;
    logic [1:0] dsel;
    logic [15:0] target;
    logic [16:0] up_sum;
    logic [31:0] mrg;
    logic [31:0] rd_word;
    logic [ADDR_W-1:0] wa;

    assign forward_run = fn_active(r_ff.in_map, r_ff.deb[5:0], FN_FWD);
    assign reverse_run = fn_active(r_ff.in_map, r_ff.deb[5:0], FN_REV);
    assign coast = fn_active(r_ff.in_map, r_ff.deb[5:0], FN_COAST);
    assign fault_rst = fn_active(r_ff.in_map, r_ff.deb[5:0], FN_RST);
    assign ext_trip = fn_active(r_ff.in_map, 6'h3f, FN_EXT) &&
        !fn_active(r_ff.in_map, r_ff.deb[5:0], FN_EXT);
    assign dsel = {fn_active(r_ff.in_map, r_ff.deb[5:0], FN_DS1),
                   fn_active(r_ff.in_map, r_ff.deb[5:0], FN_DS0)};
    assign alarm_set = r_ff.l2[2] || ext_trip;
    assign thermal_open = r_ff.deb[6] && r_ff.l2[1];
    assign warn = r_ff.l2[0];
    assign key_one = (r_ff.deb[7] ^ r_ff.deb[8]) && TOP_SCREEN;
    assign ramp_tick = r_ff.ramp_cnt == RAMP_LIM;
    assign want = forward_run ^ reverse_run;
    assign fire = key_one && r_ff.hold_cnt == HOLD_LIM - 1'b1;
    assign wa = r_ff.awaddr;

    always_comb begin
        rd_word = 32'h0000_0000;
        if (AXI_REQ.araddr == A_CTRL) begin
            rd_word[0] = r_ff.dir_swap;
        end else if (AXI_REQ.araddr == A_IN_MAP) begin
            rd_word[17:0] = r_ff.in_map;
        end else if (AXI_REQ.araddr == A_OUT_MAP) begin
            rd_word[3:0] = r_ff.out_map;
        end else if (AXI_REQ.araddr == A_ACCEL) begin
            rd_word[15:0] = r_ff.accel;
        end else if (AXI_REQ.araddr == A_DECEL) begin
            rd_word[15:0] = r_ff.decel;
        end else if (AXI_REQ.araddr >= A_SPEED0 &&
                     AXI_REQ.araddr <= A_SPEED3) begin
            rd_word[15:0] = r_ff.op_speed[AXI_REQ.araddr[3:2] - 2'h1];
        end else if (AXI_REQ.araddr == A_STATUS) begin
            rd_word[17:0] = {dsel, 1'b0, thermal_open, warn, r_ff.dir_rev,
                r_ff.running, r_ff.ind, r_ff.lock, r_ff.alarm_code,
                3'h0, r_ff.alarm};
        end else if (AXI_REQ.araddr == A_SPEED_NOW) begin
            rd_word[15:0] = r_ff.speed;
        end
    end

    always_comb begin
        nxt_r = r_ff;
        target = 16'h0000;
        up_sum = 17'h0_0000;
        mrg = 32'h0000_0000;
        // Two-stage synchronisers, then a two-sample debounce of the terminals, thermal pin and keys
        nxt_r.s1 = {KEY_MODE, KEY_SET, THERMAL_PIN, IN_TERM};
        nxt_r.s2 = r_ff.s1;
        nxt_r.l1 = {PROT_FAULT, AC_POWER, WARN_COND};
        nxt_r.l2 = r_ff.l1;
        nxt_r.deb_cnt = r_ff.deb_cnt + 1'b1;
        if (r_ff.deb_cnt == DEB_LIM) begin
            nxt_r.deb_cnt = '0;
            nxt_r.samp = r_ff.s2;
            for (int i = 0; i < NUM_DEB; i++) begin
                if (r_ff.s2[i] == r_ff.samp[i]) begin
                    nxt_r.deb[i] = r_ff.s2[i];
                end
            end
        end
        nxt_r.ramp_cnt = ramp_tick ? '0 : r_ff.ramp_cnt + 1'b1;

        // Alarm: set wins over a clear in the same cycle
        nxt_r.rst_prev = fault_rst;
        if (fault_rst && !r_ff.rst_prev && !forward_run && !reverse_run) begin
            nxt_r.alarm = 1'b0;
            nxt_r.alarm_code = ALM_NONE;
        end
        if (alarm_set) begin
            if (!nxt_r.alarm) begin
                nxt_r.alarm_code = ext_trip ? ALM_EXT : ALM_PROT;
            end
            nxt_r.alarm = 1'b1;
        end

        // Run control
        if (r_ff.alarm || coast) begin
            nxt_r.running = 1'b0;
            nxt_r.speed = 16'h0000;
            nxt_r.brake = 1'b0;
        end else if (forward_run && reverse_run) begin
            nxt_r.running = 1'b0;
            nxt_r.speed = 16'h0000;
            nxt_r.brake = 1'b1;
        end else begin
            nxt_r.brake = 1'b0;
            if (want && r_ff.speed == 16'h0000) begin
                nxt_r.running = 1'b1;
                nxt_r.dir_rev = reverse_run;
            end
            if (want && nxt_r.dir_rev == reverse_run) begin
                target = r_ff.op_speed[dsel];
            end
            if (ramp_tick && r_ff.speed < target) begin
                up_sum = {1'b0, r_ff.speed} + {1'b0, r_ff.accel};
                nxt_r.speed = up_sum > {1'b0, target} ? target :
                    up_sum[15:0];
            end else if (ramp_tick && r_ff.speed > target) begin
                nxt_r.speed = r_ff.speed - target > r_ff.decel ?
                    r_ff.speed - r_ff.decel : target;
            end
            if (!want && r_ff.speed == 16'h0000) begin
                nxt_r.running = 1'b0;
            end
        end

        // Tach: two edges per pulse, twelve pulses per revolution
        nxt_r.tach_acc = r_ff.tach_acc + 32'(r_ff.speed) * TACH_STEP;
        if (nxt_r.tach_acc >= TACH_WRAP) begin
            nxt_r.tach_acc = nxt_r.tach_acc - TACH_WRAP;
            nxt_r.tach = !r_ff.tach;
        end

        for (int i = 0; i < NUM_OUT; i++) begin
            case (r_ff.out_map[i])
                OS_TACH: nxt_r.out_term[i] = r_ff.tach;
                OS_ALMOK: nxt_r.out_term[i] = !r_ff.alarm;
                OS_THERM: nxt_r.out_term[i] = thermal_open;
                default: nxt_r.out_term[i] = warn;
            endcase
        end

        // Panel hold keys and indications
        if (!key_one) begin
            nxt_r.hold_cnt = '0;
        end else if (r_ff.hold_cnt != HOLD_LIM) begin
            nxt_r.hold_cnt = r_ff.hold_cnt + 1'b1;
        end
        if (r_ff.ind_cnt != '0) begin
            nxt_r.ind_cnt = r_ff.ind_cnt - 1'b1;
            if (r_ff.ind_cnt == CNT_W'(1)) begin
                nxt_r.ind = IND_NONE;
            end
        end
        if (fire) begin
            nxt_r.lock = r_ff.deb[7];
            nxt_r.ind = r_ff.deb[7] ? IND_LOCK : IND_UNLOCK;
            nxt_r.ind_cnt = IND_LIM;
        end

        // Register bus
        if (AXI_REQ.awvalid && AXI_RSP.awready) begin
            nxt_r.aw_got = 1'b1;
            nxt_r.awaddr = AXI_REQ.awaddr;
        end
        if (AXI_REQ.wvalid && AXI_RSP.wready) begin
            nxt_r.w_got = 1'b1;
            nxt_r.wdata = AXI_REQ.wdata;
            nxt_r.wstrb = AXI_REQ.wstrb;
        end
        if (r_ff.bvalid && AXI_REQ.bready) begin
            nxt_r.bvalid = 1'b0;
        end
        if (r_ff.aw_got && r_ff.w_got) begin
            nxt_r.aw_got = 1'b0;
            nxt_r.w_got = 1'b0;
            nxt_r.bvalid = 1'b1;
            nxt_r.bresp = RESP_OKAY;
            if (wa == A_CTRL) begin
                mrg = wr_merge({31'h0, r_ff.dir_swap}, r_ff.wdata,
                    r_ff.wstrb);
                nxt_r.dir_swap = mrg[0];
            end else if (wa == A_IN_MAP) begin
                mrg = wr_merge({14'h0, r_ff.in_map}, r_ff.wdata, r_ff.wstrb);
                nxt_r.in_map = mrg[17:0];
            end else if (wa == A_OUT_MAP) begin
                mrg = wr_merge({28'h0, r_ff.out_map}, r_ff.wdata,
                    r_ff.wstrb);
                nxt_r.out_map = mrg[3:0];
            end else if (wa == A_ACCEL) begin
                mrg = wr_merge({16'h0, r_ff.accel}, r_ff.wdata, r_ff.wstrb);
                nxt_r.accel = mrg[15:0];
            end else if (wa == A_DECEL) begin
                mrg = wr_merge({16'h0, r_ff.decel}, r_ff.wdata, r_ff.wstrb);
                nxt_r.decel = mrg[15:0];
            end else if (wa >= A_SPEED0 && wa <= A_SPEED3) begin
                mrg = wr_merge({16'h0, r_ff.op_speed[wa[3:2] - 2'h1]},
                    r_ff.wdata, r_ff.wstrb);
                nxt_r.op_speed[wa[3:2] - 2'h1] = mrg[15:0];
            end else begin
                nxt_r.bresp = RESP_SLVERR;
            end
            if (r_ff.lock && wa <= A_SPEED3) begin
                nxt_r.dir_swap = r_ff.dir_swap;
                nxt_r.in_map = r_ff.in_map;
                nxt_r.out_map = r_ff.out_map;
                nxt_r.accel = r_ff.accel;
                nxt_r.decel = r_ff.decel;
                nxt_r.op_speed = r_ff.op_speed;
                nxt_r.bresp = RESP_SLVERR;
                nxt_r.ind = IND_LOCKED_EDIT;
                nxt_r.ind_cnt = IND_LIM;
            end
        end
        if (r_ff.rvalid && AXI_REQ.rready) begin
            nxt_r.rvalid = 1'b0;
        end
        if (AXI_REQ.arvalid && AXI_RSP.arready) begin
            nxt_r.rvalid = 1'b1;
            nxt_r.rdata = rd_word;
            nxt_r.rresp = AXI_REQ.araddr > A_SPEED_NOW ? RESP_SLVERR :
                RESP_OKAY;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            r_ff <= '0;
            r_ff.in_map <= RST_IN_MAP;
            r_ff.out_map <= RST_OUT_MAP;
            r_ff.accel <= RST_STEP;
            r_ff.decel <= RST_STEP;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign AXI_RSP.awready = !r_ff.aw_got && !r_ff.bvalid;
    assign AXI_RSP.wready = !r_ff.w_got && !r_ff.bvalid;
    assign AXI_RSP.bvalid = r_ff.bvalid;
    assign AXI_RSP.bresp = r_ff.bresp;
    assign AXI_RSP.arready = !r_ff.rvalid;
    assign AXI_RSP.rvalid = r_ff.rvalid;
    assign AXI_RSP.rdata = r_ff.rdata;
    assign AXI_RSP.rresp = r_ff.rresp;
    assign OUT_TERM = r_ff.out_term;
    assign MOTOR_DRIVE = r_ff.running;
    assign MOTOR_CW = !(r_ff.dir_rev ^ r_ff.dir_swap);
    assign MOTOR_BRAKE = r_ff.brake;
    assign SPEED_REF = r_ff.speed;
    assign ALARM_LED = r_ff.alarm;
    assign ALARM_CODE = r_ff.alarm_code;
    assign PANEL_IND = r_ff.ind;
    assign EDIT_LOCKED = r_ff.lock;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    property p_both_stop;
        forward_run && reverse_run && !r_ff.alarm && !coast |=> r_ff.speed == 16'h0000
            && r_ff.brake && !r_ff.running;
    endproperty
    a_both_stop: assert property (p_both_stop)
        else $error("both run inputs did not stop motor");
    property p_coast;
        coast |=> !MOTOR_DRIVE && SPEED_REF == 16'h0000;
    endproperty
    a_coast: assert property (p_coast)
        else $error("drive present during coast");
    // A reset edge may clear the alarm at once, so check only the next edge
    property p_alarm_coast;
        r_ff.alarm |=> !MOTOR_DRIVE
            && (!OUT_TERM[1] || $past(r_ff.out_map[1]) != OS_ALMOK);
    endproperty
    a_alarm_coast: assert property (p_alarm_coast)
        else $error("alarm did not coast motor");
    property p_ext;
        ext_trip && !r_ff.alarm |=> r_ff.alarm && ALARM_CODE == ALM_EXT;
    endproperty
    a_ext: assert property (p_ext)
        else $error("external fault did not raise its alarm");
    property p_rst_blocked;
        r_ff.alarm && (forward_run || reverse_run) |=> r_ff.alarm;
    endproperty
    a_rst_blocked: assert property (p_rst_blocked)
        else $error("alarm cleared while running");
    property p_rst_level;
        r_ff.alarm && r_ff.rst_prev |=> r_ff.alarm;
    endproperty
    a_rst_level: assert property (p_rst_level)
        else $error("alarm cleared on reset level");
    property p_warn;
        r_ff.out_map[1] == OS_WARN |=> OUT_TERM[1] == $past(r_ff.l2[0]);
    endproperty
    a_warn: assert property (p_warn)
        else $error("warning output does not follow warning");
    property p_alarm_ok;
        r_ff.out_map[1] == OS_ALMOK |=> OUT_TERM[1] == !$past(r_ff.alarm);
    endproperty
    a_alarm_ok: assert property (p_alarm_ok)
        else $error("alarm ok output wrong");
    property p_lock_wr;
        r_ff.lock && r_ff.aw_got && r_ff.w_got |=> AXI_RSP.bvalid
            && AXI_RSP.bresp == RESP_SLVERR && $stable(r_ff.op_speed);
    endproperty
    a_lock_wr: assert property (p_lock_wr)
        else $error("write accepted while locked");
    property p_tach_still;
        r_ff.speed == 16'h0000 && r_ff.tach_acc < TACH_WRAP
            |=> $stable(r_ff.tach);
    endproperty
    a_tach_still: assert property (p_tach_still)
        else $error("tach moved at standstill");
    c_fwd_run: cover property (forward_run && !reverse_run ##1 MOTOR_DRIVE);
    c_alarm_clear: cover property (r_ff.alarm ##1 !r_ff.alarm);
    c_lock: cover property (!r_ff.lock ##1 r_ff.lock);
endmodule

/* File: verification/mioac_ctrl_model.sv */
// Machine controller model driving the terminal inputs
`timescale 1ns/10ps
module mioac_ctrl_model (
    // Clock, requested levels, terminal pins
    input wire logic clk,
    input wire logic [5:0] cmd,
    output logic [5:0] term
);
    always_ff @(posedge clk) begin
        term <= cmd;
    end
endmodule

/* File: verification/test_mioac_top.sv */
// Self-checking bench of the motor I/O and alarm block
`timescale 1ns/10ps
module test_mioac_top;
    import mioac_pkg::*;
    typedef struct packed {
        logic [5:0] in;
        logic [15:0] spd;
        logic cw;
        logic drv;
        logic brk;
    } mioac_row_t;
    logic clk = 1'h0;
    logic rst = 1'h1;
    mioac_axi_req_t req = '0;
    mioac_axi_rsp_t rsp;
    logic [5:0] cmd = 6'h00;
    logic [5:0] term;
    logic th = 1'h0, ac = 1'h0, wn = 1'h0, pf = 1'h0;
    logic ks = 1'h0, km = 1'h0, ts = 1'h0;
    logic [1:0] ot, ind;
    logic drv, cw, brk, led, lkd;
    logic [15:0] spd;
    logic [3:0] code;
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;
    int n = 0;
    logic t0 = 1'h0;
    localparam int unsigned TACH_RPM = 62500;
    localparam int unsigned TACH_HALF =
        CLK_HZ * SEC_PER_MIN / (2 * TACH_PULSES_REV * TACH_RPM);
    mioac_row_t rows [7];
    mioac_ctrl_model mioac_ctrl_model_i (.clk(clk), .cmd(cmd), .term(term));
    mioac_top #(.DEB_CYCLES(4), .RAMP_CYCLES(8), .HOLD_CYCLES(50),
        .IND_CYCLES(20)) mioac_top_i (.CLK(clk), .RESET(rst),
        .AXI_REQ(req), .AXI_RSP(rsp), .IN_TERM(term), .THERMAL_PIN(th),
        .AC_POWER(ac), .WARN_COND(wn), .PROT_FAULT(pf), .KEY_SET(ks),
        .KEY_MODE(km), .TOP_SCREEN(ts), .OUT_TERM(ot), .MOTOR_DRIVE(drv),
        .MOTOR_CW(cw), .MOTOR_BRAKE(brk), .SPEED_REF(spd),
        .ALARM_LED(led), .ALARM_CODE(code), .PANEL_IND(ind),
        .EDIT_LOCKED(lkd));
    initial begin
        forever #10 clk = ~clk;
    end
    // Watchdog: the whole run needs about 6000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] s);
        num_checks++;
        if (s !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] e);
        req.awvalid <= 1'h1;
        req.awaddr <= a;
        req.wvalid <= 1'h1;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.bready <= 1'h1;
        forever begin
            @(posedge clk);
            if (rsp.awready) req.awvalid <= 1'h0;
            if (rsp.wready) req.wvalid <= 1'h0;
            if (rsp.bvalid) break;
        end
        req.bready <= 1'h0;
        chk("bresp", 32'(e), 32'(rsp.bresp));
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
        input logic [1:0] r);
        req.arvalid <= 1'h1;
        req.araddr <= a;
        req.rready <= 1'h1;
        forever begin
            @(posedge clk);
            if (rsp.arready) req.arvalid <= 1'h0;
            if (rsp.rvalid) break;
        end
        req.rready <= 1'h0;
        chk("rdata", e, rsp.rdata);
        chk("rresp", 32'(r), 32'(rsp.rresp));
        @(posedge clk);
    endtask
    initial begin
        rows[0] = {6'h01, 16'h0064, 3'h6};
        rows[1] = {6'h05, 16'h00c8, 3'h6};
        rows[2] = {6'h09, 16'h012c, 3'h6};
        rows[3] = {6'h0d, 16'h0190, 3'h6};
        rows[4] = {6'h02, 16'h0064, 3'h2};
        rows[5] = {6'h03, 16'h0000, 3'h1};
        rows[6] = {6'h21, 16'h0000, 3'h0};
        cyc(2);
        rst <= 1'h0;
        cyc(3);
        chk("out", 32'h0000_0002, 32'(ot));
        rd(A_IN_MAP, 32'(RST_IN_MAP), RESP_OKAY);
        rd(A_DECEL, 32'(RST_STEP), RESP_OKAY);
        wr(A_IN_MAP, 32'h0003_58d1, RESP_OKAY);
        wr(A_ACCEL, 32'h0000_1000, RESP_OKAY);
        wr(A_DECEL, 32'h0000_1000, RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            wr(A_SPEED0 + 8'(4 * i), 32'h0000_0064 * (i + 1),
                RESP_OKAY);
        end
        foreach (rows[i]) begin
            cmd <= rows[i].in;
            cyc(40);
            chk("spd", 32'(rows[i].spd), 32'(spd));
            chk("drv", 32'(rows[i].drv), 32'(drv));
            chk("brk", 32'(rows[i].brk), 32'(brk));
            if (rows[i].drv) chk("cw", 32'(rows[i].cw), 32'(cw));
            cmd <= 6'h00;
            cyc(40);
            chk("stop", 32'h0000_0000, 32'(spd));
        end
        wr(A_CTRL, 32'h0000_0001, RESP_OKAY);
        cmd <= 6'h01;
        cyc(40);
        chk("swap", 32'h0000_0000, 32'(cw));
        // Tach half period at a speed that divides the clock evenly
        wr(A_SPEED0, 32'(TACH_RPM), RESP_OKAY);
        cyc(200);
        t0 = ot[0];
        while (ot[0] === t0) @(posedge clk);
        n = 0;
        while (ot[0] !== t0) begin
            @(posedge clk);
            n++;
        end
        chk("tach", TACH_HALF, n);
        wr(A_SPEED0, 32'h0000_0064, RESP_OKAY);
        cmd <= 6'h21;
        cyc(40);
        chk("coast", 32'h0000_0000, 32'(drv));
        pf <= 1'h1;
        cyc(8);
        chk("alm", 32'({1'h1, ALM_PROT, 2'h0}),
            32'({led, code, ot[1], drv}));
        pf <= 1'h0;
        cmd <= 6'h11;
        cyc(40);
        chk("busy", 32'h0000_0001, 32'(led));
        cmd <= 6'h10;
        cyc(40);
        chk("level", 32'h0000_0001, 32'(led));
        cmd <= 6'h00;
        cyc(40);
        cmd <= 6'h10;
        cyc(40);
        chk("clear", 32'h0000_0003, 32'({led, ot[1], ~drv}));
        wr(A_IN_MAP, 32'h0003_d8d1, RESP_OKAY);
        cyc(40);
        chk("ext", 32'({1'h1, ALM_EXT}), 32'({led, code}));
        cmd <= 6'h20;
        cyc(40);
        cmd <= 6'h30;
        cyc(40);
        chk("extclr", 32'h0000_0000, 32'(led));
        wr(A_OUT_MAP, 32'h0000_000e, RESP_OKAY);
        ac <= 1'h1;
        th <= 1'h1;
        wn <= 1'h1;
        cyc(30);
        chk("thwn", 32'h0000_0003, 32'(ot));
        ac <= 1'h0;
        cyc(10);
        chk("thac", 32'h0000_0002, 32'(ot));
        th <= 1'h0;
        wn <= 1'h0;
        cyc(30);
        chk("thwn", 32'h0000_0000, 32'(ot));
        wr(8'h2c, 32'h0000_0000, RESP_SLVERR);
        rd(8'h30, 32'h0000_0000, RESP_SLVERR);
        ts <= 1'h1;
        ks <= 1'h1;
        cyc(30);
        chk("early", 32'h0000_0000, 32'(lkd));
        while (lkd !== 1'h1) @(posedge clk);
        chk("lk", 32'(IND_LOCK), 32'(ind));
        ks <= 1'h0;
        wr(A_SPEED0, 32'h0000_0099, RESP_SLVERR);
        chk("lf", 32'(IND_LOCKED_EDIT), 32'(ind));
        rd(A_SPEED0, 32'h0000_0064, RESP_OKAY);
        cyc(25);
        chk("ind", 32'(IND_NONE), 32'(ind));
        km <= 1'h1;
        while (lkd !== 1'h0) @(posedge clk);
        chk("unlock_indication", 32'(IND_UNLOCK), 32'(ind));
        // Reset in mid-run returns outputs and settings to their defaults
        rst <= 1'h1;
        cyc(2);
        rst <= 1'h0;
        cyc(3);
        chk("rst", 32'h0000_0002, 32'({lkd, ind, ot}));
        rd(A_CTRL, 32'h0000_0000, RESP_OKAY);
        end_sim();
    end
endmodule
